// *** rtl/crsm_pkg.sv ***
package crsm_pkg;

  localparam logic [7:0] CRSM_CTRL_ON       = 8'hE4;
  localparam logic [7:0] CRSM_CTRL_OFF      = 8'h00;

  // Register word offsets (byte addresses)
  localparam logic [3:0] CRSM_OFS_CTRL      = 4'h0;
  localparam logic [3:0] CRSM_OFS_LOW       = 4'h4;
  localparam logic [3:0] CRSM_OFS_HIGH      = 4'h8;
  localparam logic [3:0] CRSM_OFS_STATUS    = 4'hC;

  localparam logic [7:0] CRSM_RST_CTRL      = 8'h00;
  localparam logic [7:0] CRSM_RST_LOW       = 8'h00;
  localparam logic [7:0] CRSM_RST_HIGH      = 8'hFF;

  // Status layout
  localparam int         CRSM_ST_FLAG_BIT   = 0;
  localparam int         CRSM_ST_RST_BIT    = 1;
  localparam int         CRSM_ST_EN_BIT     = 2;
  localparam int         CRSM_ST_CLR_BIT    = 0;

  localparam int         CRSM_RATIO_DIV     = 4;
  localparam int         CRSM_EDGES_TO_RST  = 2;
  localparam int         CRSM_HOLD_CYC      = 24;
  localparam int         CRSM_FLASH_CYC     = 1024;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } crsm_wb_req_t;

  typedef enum logic [2:0] {
    CRSM_IDLE  = 3'b001,
    CRSM_HOLD  = 3'b010,
    CRSM_FLASH = 3'b100
  } crsm_state_t;

endpackage

// *** rtl/crsm_monitor.sv ***
// What this block does
// - E4H enables monitoring, 00H disables it
// - Enable refused unless both oscillators enabled
// - Main oscillator cleared forces control to 00H
// - Halt mode entry clears control; rewrite needed
// - Control survives internal reset; pin reset only
// - Limit writes ignored while monitoring enabled
// - Limits survive internal reset; pin reset only
// - Reset asserted after two more slow edges
// - Monitor runs during reset; released when in range
// - Stopped slow clock yields no reset
// - Flash reset follows; hold restarts on each bad verdict
// - Transient excursions also trigger reset
// - Sub oscillator kept running while enabled
// - Cause flag set; cleared by strobe or pin
`timescale 1ns/1ps
`default_nettype none
module crsm_monitor #(
  parameter int CNT_W = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 int_rst_i,
  input  wire logic                 slow_clk_i,
  input  wire logic                 main_osc_enable_i,
  input  wire logic                 sub_osc_enable_i,
  input  wire logic                 halt_entry_i,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [3:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  output logic                      monitor_reset_o,
  output logic                      sub_osc_keep_o,
  output logic                      irq_o
);
  import crsm_pkg::*;

  // Register map, byte offsets on the word bus:
  //   control      E4 arms the monitor, 00 disarms it, others ignored
  //   lower limit  least fast/4 count allowed per slow period
  //   upper limit  most fast/4 count allowed per slow period
  //   status       read: flag, reset active, armed from bit 0 up
  //                write: bit 0 clears the flag, bit 8 irq enable
  //   limits reset to 00 and FF, the widest window
  // Other offsets read as zero and ignore writes. Only byte lane 0
  // reaches the 8-bit registers; lane 1 carries the interrupt enable.
  // Every request is answered one cycle after it is taken.
  //
  // Reset timing: a period is judged at the slow edge that closes it,
  // the verdict walks through two more slow edges, the hold then runs
  // for a fixed time after the last bad verdict, and the flash phase
  // ends the sequence.

  logic [7:0]       ctrl_ff;
  logic [7:0]       low_ff;
  logic [7:0]       high_ff;
  logic             flag_ff;
  logic             irq_en_ff;
  logic             ack_ff;
  logic [31:0]      rdat_ff;
  logic             slow_q_ff;
  logic [1:0]       pre_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             sat_ff;
  logic [1:0]       pend_ff;
  logic             bad_ff;
  logic [10:0]      tmr_ff;
  crsm_state_t      state_ff;
  logic             main_q_ff;
  logic             enabled;
  logic             req;
  logic             wr;
  logic             slow_rise;
  logic             out_range;
  logic             monitor_evt;
  logic             primed_ff;
  logic             irq_wr;

  // Armed only by the exact code, not by any single bit of it
  assign enabled   = (ctrl_ff == CRSM_CTRL_ON);
  // A request still held is not taken again in the cycle its ack is up
  assign req       = cyc_i && stb_i && !ack_ff;
  assign wr        = req && we_i && sel_i[0];
  assign slow_rise = slow_clk_i && !slow_q_ff;

  function automatic logic wr_at(input logic [3:0] ofs);
    return wr && (adr_i == ofs);
  endfunction

  // Lane 1 alone carries the interrupt enable
  assign irq_wr = req && we_i && sel_i[1] && (adr_i == CRSM_OFS_STATUS);

  // Window test for one closed period
  function automatic logic out_of_window(input logic [CNT_W-1:0] cnt,
                                         input logic             sat,
                                         input logic [7:0]       lo,
                                         input logic [7:0]       hi);
    return sat || (cnt < lo[CNT_W-1:0]) || (cnt > hi[CNT_W-1:0]);
  endfunction

  // Status word bits from the package layout
  function automatic logic [31:0] status_word(input logic en,
                                              input logic act,
                                              input logic flg);
    logic [31:0] w;
    w                   = 32'h0000_0000;
    w[CRSM_ST_EN_BIT]   = en;
    w[CRSM_ST_RST_BIT]  = act;
    w[CRSM_ST_FLAG_BIT] = flg;
    return w;
  endfunction

  // Registered ack gives one wait state and drops by itself, so a master
  // that holds cyc and stb sees exactly one ack per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Read data is captured at the request edge and stands with the ack;
  // unmapped offsets and idle cycles read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req && !we_i) begin
      unique case (adr_i)
        CRSM_OFS_CTRL:   rdat_ff <= {24'h00_0000, ctrl_ff};
        CRSM_OFS_LOW:    rdat_ff <= {24'h00_0000, low_ff};
        CRSM_OFS_HIGH:   rdat_ff <= {24'h00_0000, high_ff};
        CRSM_OFS_STATUS: rdat_ff <= status_word(enabled, monitor_reset_o,
                                                flag_ff);
        default:         rdat_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdat_ff <= 32'h0000_0000;
    end
  end
  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;

  // Internal reset never touches control; only rst_i (pin) does
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff   <= CRSM_RST_CTRL;
      main_q_ff <= 1'b0;
    end else begin
      main_q_ff <= main_osc_enable_i;
      // Halt entry outranks any write, so a mode switch never leaves
      // monitoring armed on a clock that is about to stop
      if (halt_entry_i) begin
        ctrl_ff <= CRSM_CTRL_OFF;
      end else if (enabled && !main_osc_enable_i) begin
        ctrl_ff <= CRSM_CTRL_OFF;
      // Both enables are checked at the write; after it only the main enable is
      // watched, so a later drop of the sub enable alone leaves monitoring armed
      end else if (wr_at(CRSM_OFS_CTRL)) begin
        if (dat_i[7:0] == CRSM_CTRL_OFF) begin
          ctrl_ff <= CRSM_CTRL_OFF;
        end else if (dat_i[7:0] == CRSM_CTRL_ON &&
                     main_osc_enable_i && sub_osc_enable_i) begin
          ctrl_ff <= CRSM_CTRL_ON;
        end
      end
    end
  end

  // Limits locked while enabled, kept over internal reset
  // A write while armed is dropped, not queued: disarm first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_ff  <= CRSM_RST_LOW;
      high_ff <= CRSM_RST_HIGH;
    end else if (!enabled) begin
      if (wr_at(CRSM_OFS_LOW)) begin
        low_ff <= dat_i[7:0];
      end
      if (wr_at(CRSM_OFS_HIGH)) begin
        high_ff <= dat_i[7:0];
      end
    end
  end

  // Fast cycles divided by four, counted per slow period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_q_ff <= 1'b0;
      pre_ff    <= 2'b00;
      cnt_ff    <= '0;
      sat_ff    <= 1'b0;
    end else begin
      // Slow clock is a synchronous level; one flop gives its edges
      slow_q_ff <= slow_clk_i;
      if (!enabled) begin
        pre_ff <= 2'b00;
        cnt_ff <= '0;
        sat_ff <= 1'b0;
      end else if (slow_rise) begin
        // Prescaler restarts so every period is counted alike
        pre_ff <= 2'b00;
        cnt_ff <= '0;
        sat_ff <= 1'b0;
      end else begin
        pre_ff <= pre_ff + 2'b01;
        if (pre_ff == 2'(CRSM_RATIO_DIV - 1)) begin
          // Saturates instead of wrapping: a long period stays bad
          if (&cnt_ff) begin
            sat_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      end
    end
  end
  assign out_range = bad_ff;

  // The first slow edge after arming only opens the window: the period
  // before it was cut short and would read as a false excursion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primed_ff <= 1'b0;
    end else if (!enabled) begin
      primed_ff <= 1'b0;
    end else if (slow_rise) begin
      primed_ff <= 1'b1;
    end
  end

  // Verdict on the period that a slow edge has just closed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bad_ff <= 1'b0;
    end else if (!enabled) begin
      bad_ff <= 1'b0;
    end else if (slow_rise) begin
      // Dead slow clock: no edge, so no verdict and no reset
      bad_ff <= primed_ff && out_of_window(cnt_ff, sat_ff,
                                           low_ff, high_ff);
    end
  end

  // Verdict shifts through two more slow edges before reset
  // One bad period walks through both stages on its own
  // Cleared when disarmed so a stale verdict cannot fire on re-arming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= 2'b00;
    end else if (!enabled) begin
      pend_ff <= 2'b00;
    end else if (slow_rise) begin
      pend_ff <= {pend_ff[0], out_range};
    end
  end
  assign monitor_evt = pend_ff[CRSM_EDGES_TO_RST-1];

  // Hold, then flash reset after every monitor reset
  // Reset lasts the hold after the last bad verdict plus the flash;
  // the flash phase always runs to its end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= CRSM_IDLE;
      tmr_ff   <= '0;
    end else begin
      unique case (state_ff)
        CRSM_IDLE: begin
          // Each entry also sets the cause flag below
          if (monitor_evt) begin
            state_ff <= CRSM_HOLD;
            tmr_ff   <= 11'(CRSM_HOLD_CYC - 1);
          end
        end
        CRSM_HOLD: begin
          // Held while out of range; monitoring keeps running
          if (monitor_evt) begin
            tmr_ff <= 11'(CRSM_HOLD_CYC - 1);
          end else if (tmr_ff == '0 || !enabled) begin
            // Disarming ends the hold early; the flash part still runs
            state_ff <= CRSM_FLASH;
            tmr_ff   <= 11'(CRSM_FLASH_CYC - 1);
          end else begin
            tmr_ff <= tmr_ff - 1'b1;
          end
        end
        CRSM_FLASH: begin
          // A new bad verdict is taken up only once back in idle
          if (tmr_ff == '0) begin
            state_ff <= CRSM_IDLE;
          end else begin
            tmr_ff <= tmr_ff - 1'b1;
          end
        end
        default: state_ff <= CRSM_IDLE;
      endcase
    end
  end
  assign monitor_reset_o = (state_ff != CRSM_IDLE);

  // Cause flag: set wins over clear
  // Internal reset has no path to it; the pin reset and strobe do
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else if (state_ff == CRSM_IDLE && monitor_evt) begin
      flag_ff <= 1'b1;
    end else if (wr_at(CRSM_OFS_STATUS) && dat_i[CRSM_ST_CLR_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  // Interrupt enable in status bit 8, written through lane 1 alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_ff <= 1'b0;
    end else if (irq_wr) begin
      irq_en_ff <= dat_i[8];
    end
  end
  // Level output: clearing the flag or the enable drops it
  assign irq_o = flag_ff && irq_en_ff;

  // Keep slow oscillator alive while enabled
  // Internal reset has no path here, so the oscillator rides it out
  assign sub_osc_keep_o = enabled;

  // Internal reset and the upper byte lanes are not decoded
  wire unused_ok = &{1'b0, int_rst_i, main_q_ff, sel_i[3:2], dat_i[31:9]};

endmodule
`default_nettype wire

// *** verif/crsm_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module crsm_monitor_chk import crsm_pkg::*; #(
  parameter int CNT_W = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        int_rst_i,
  input wire logic        main_osc_enable_i,
  input wire logic        sub_osc_enable_i,
  input wire logic        halt_entry_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        monitor_reset_o,
  input wire logic        sub_osc_keep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = cyc_i && stb_i && !ack_o;
  wire logic on_try = take && we_i && sel_i[0] && adr_i == CRSM_OFS_CTRL
    && dat_i[7:0] == CRSM_CTRL_ON;
  a_ack_pulse: assert property (take |=> ack_o ##1 !ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (ack_o |-> $past(take))
    else $error("ack without request");
  a_enable_refused: assert property (
    on_try && !sub_osc_keep_o && !(main_osc_enable_i && sub_osc_enable_i)
    |=> !sub_osc_keep_o [*3]) else $error("enable taken without osc");
  a_main_off_clears: assert property (
    sub_osc_keep_o && !main_osc_enable_i |-> ##[1:2] !sub_osc_keep_o)
    else $error("main osc off left monitor on");
  a_halt_clears: assert property (
    halt_entry_i |-> ##[1:2] !sub_osc_keep_o)
    else $error("halt entry left monitor on");
  a_int_rst_keeps: assert property (
    int_rst_i && !cyc_i && main_osc_enable_i && !halt_entry_i
    |=> $stable(sub_osc_keep_o)) else $error("internal reset hit control");
  a_reset_min_len: assert property (
    $rose(monitor_reset_o) |-> monitor_reset_o [*8])
    else $error("monitor reset too short");
  a_reset_needs_on: assert property (
    $rose(monitor_reset_o) |-> $past(sub_osc_keep_o))
    else $error("monitor reset while disabled");
  c_enable: cover property ($rose(sub_osc_keep_o));
  c_reset: cover property ($fell(monitor_reset_o));
  c_refuse: cover property (on_try && !sub_osc_enable_i);
endmodule
bind crsm_monitor crsm_monitor_chk #(.CNT_W(CNT_W)) i_crsm_monitor_chk (.*);
`default_nettype wire

// *** verif/crsm_slow_osc.sv ***
`timescale 1ns/1ps
`default_nettype none
module crsm_slow_osc (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output var  logic       slow_clk_o = 1'b0
);
  logic [7:0] cnt_ff = 8'h00;
  wire logic  wrap = cnt_ff + 8'h01 >= half_i;
  // Runs from time zero, stable before any write
  // Stopped oscillator gives no edges at all
  always_ff @(posedge clk_i) begin
    if (run_i) begin
      cnt_ff <= wrap ? 8'h00 : cnt_ff + 8'h01;
      if (wrap) slow_clk_o <= !slow_clk_o;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crsm_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, int_rst_i = 1'b0, run = 1'b1;
  logic        main_osc_enable_i = 1'b1, sub_osc_enable_i = 1'b0;
  logic        halt_entry_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [7:0]  half = 8'h10;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        slow_clk_i, ack_o, monitor_reset_o, sub_osc_keep_o, irq_o;
  int          error_cnt = 0, tests_run = 0, n;
  // Write, offset, data, read; limits 4..12 around ratio 8
  logic [20:0] rows [10] = '{21'h000000, 21'h040000, 21'h0800FF,
    21'h140400, 21'h180C00, 21'h125500, 21'h040004, 21'h08000C,
    21'h105500, 21'h000000};
  crsm_monitor i_crsm_monitor (.*);
  crsm_slow_osc i_crsm_slow_osc (.clk_i, .run_i(run), .half_i(half),
    .slow_clk_o(slow_clk_i));
  always #20 clk_i = ~clk_i;
  task automatic wrap_up;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic bad(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) bad($sformatf("read %h, want %h", g, e));
  endtask
  task automatic chb(input logic g, input logic e);
    tests_run++;
    if (g !== e) bad("output level wrong");
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin bad("no ack"); wrap_up; end
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 32'h0, 4'h1);
    chk(q[7:0], e);
  endtask
  task automatic wt(input logic v);
    n = 0;
    while (monitor_reset_o !== v && n < 3000) begin @(posedge clk_i); n++; end
    if (n >= 3000) begin bad("reset wait"); wrap_up; end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i][20], rows[i][19:16], {24'h0, rows[i][15:8]}, 4'h1);
      if (!rows[i][20]) chk(q[7:0], rows[i][7:0]);
    end
    $display("table done");
    wb(1'b1, CRSM_OFS_CTRL, 32'hE4, 4'h1);
    rd(CRSM_OFS_CTRL, CRSM_CTRL_OFF);
    sub_osc_enable_i <= 1'b1;
    wb(1'b1, CRSM_OFS_CTRL, 32'hE4, 4'h1);
    rd(CRSM_OFS_CTRL, CRSM_CTRL_ON);
    wb(1'b1, CRSM_OFS_LOW, 32'h20, 4'h1);
    rd(CRSM_OFS_LOW, 8'h04);
    int_rst_i <= 1'b1;
    sub_osc_enable_i <= 1'b0;
    @(posedge clk_i) int_rst_i <= 1'b0;
    rd(CRSM_OFS_CTRL, CRSM_CTRL_ON);
    rd(CRSM_OFS_HIGH, 8'h0C);
    chb(sub_osc_keep_o, 1'b1);
    repeat (300) @(posedge clk_i);
    chb(monitor_reset_o, 1'b0);
    // Short excursion only: two slow periods stretched
    half <= 8'h28;
    repeat (90) @(posedge clk_i);
    half <= 8'h10;
    wt(1'b1);
    rd(CRSM_OFS_STATUS, 8'h07);
    wb(1'b1, CRSM_OFS_STATUS, 32'h100, 4'h2);
    repeat (2) @(posedge clk_i);
    chb(irq_o, 1'b1);
    wt(1'b0);
    chb(n + 16 >= CRSM_FLASH_CYC, 1'b1);
    chb(n <= CRSM_HOLD_CYC + CRSM_FLASH_CYC + 64, 1'b1);
    wb(1'b1, CRSM_OFS_STATUS, 32'h0, 4'h2);
    repeat (2) @(posedge clk_i);
    chb(irq_o, 1'b0);
    wb(1'b1, CRSM_OFS_STATUS, 32'h101, 4'h3);
    rd(CRSM_OFS_STATUS, 8'h04);
    chb(irq_o, 1'b0);
    $display("reset cycle done");
    run <= 1'b0;
    repeat (400) @(posedge clk_i);
    chb(monitor_reset_o, 1'b0);
    main_osc_enable_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chb(sub_osc_keep_o, 1'b0);
    {run, main_osc_enable_i, sub_osc_enable_i} <= 3'b111;
    wb(1'b1, CRSM_OFS_CTRL, 32'hE4, 4'h1);
    halt_entry_i <= 1'b1;
    @(posedge clk_i) halt_entry_i <= 1'b0;
    rd(CRSM_OFS_CTRL, CRSM_CTRL_OFF);
    wb(1'b1, CRSM_OFS_CTRL, 32'hE4, 4'h1);
    rd(CRSM_OFS_CTRL, CRSM_CTRL_ON);
    wb(1'b1, CRSM_OFS_CTRL, 32'h00, 4'h1);
    rd(CRSM_OFS_CTRL, CRSM_CTRL_OFF);
    $display("mode cycle done");
    wrap_up;
  end
endmodule
`default_nettype wire
